// ### rtl/cpf_delay_timer.sv
// Delay timer: counts while its condition holds, restarts when it drops.
// Assumes condition and limit come from logic on the same clock.
`timescale 1ns/1ns

module cpf_delay_timer (
    input  wire logic             sys_clk,  // 10 MHz clock
    input  wire logic             rst_n,    // Synchronous reset, low
    input  wire logic             cond,     // Triggering condition
    input  wire cpf_pkg::cpf_cnt_t limit,   // Cycles to expiry
    output logic                  expired   // Held while cond outlasted limit
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        cpf_pkg::cpf_cnt_t cnt;   // Elapsed cycles
        logic              done;  // Expired flag
    } cpf_tmr_s;

    cpf_tmr_s st;       // Registered state
    cpf_tmr_s next_st;  // Next state

    // Counter step
    always_comb begin
        next_st = st;
        if (!cond) begin
            next_st.cnt  = '0;
            next_st.done = 1'b0;
        end else if (st.cnt >= limit) begin
            // Saturate so the flag stays high
            next_st.done = 1'b1;
        end else begin
            next_st.cnt = st.cnt + cpf_pkg::cpf_cnt_t'(1);
        end
    end

    // Register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign expired = st.done;

endmodule

// ### rtl/cpf_pkg.sv
// Package for the cell protection state machine: states, timing, carriers.
// Assumes a 10 MHz system clock and comparator results arriving from pins.
package cpf_pkg;

    // ==========================================================
    // Clock and delay times
    // ==========================================================
    localparam longint CLK_HZ          = 10000000;  // System clock rate
    localparam longint OVERCHARGE_MS   = 200;       // Overcharge delay, typ
    localparam longint OVERDISCH_MS    = 50;        // Overdischarge delay, typ
    localparam longint OVERCURRENT_MS  = 10;        // Over-current delay, typ
    localparam longint SHORT_US        = 10;        // Short-circuit delay, typ
    localparam longint TEST_MS         = 50;        // Test-mode delay ceiling
    // Test-mode delay, arbitrary pick: must sit below the overdischarge
    // delay too, or the test pin would not shorten that one at all
    localparam longint TEST_US         = 200;

    // Cycle counts, longest times rounded down
    localparam longint OVERCHARGE_CYC  = OVERCHARGE_MS * CLK_HZ / 1000;
    localparam longint OVERDISCH_CYC   = OVERDISCH_MS * CLK_HZ / 1000;
    localparam longint OVERCURRENT_CYC = OVERCURRENT_MS * CLK_HZ / 1000;
    localparam longint SHORT_CYC       = SHORT_US * CLK_HZ / 1000000;
    localparam longint TEST_CYC        = TEST_US * CLK_HZ / 1000000;

    localparam int     TMR_W           = 22;        // Timer width, 2e6 fits

    typedef logic [TMR_W-1:0] cpf_cnt_t;

    // ==========================================================
    // Protection states, one-hot
    // ==========================================================
    typedef enum logic [6:0] {
        ST_NORMAL  = 7'h01,   // Both FETs on
        ST_OVCHG   = 7'h02,   // Charge FET off, cell too high
        ST_ABNCHG  = 7'h04,   // Charge FET off, charge current wrong
        ST_OVDIS   = 7'h08,   // Discharge FET off, sense pulled up
        ST_PWRDN   = 7'h10,   // Power-down, waiting on a charger
        ST_WAKE    = 7'h20,   // Out of power-down, awaiting release
        ST_OVCUR   = 7'h40    // Over-current or short, pull-down on
    } cpf_state_e;

    // ==========================================================
    // Comparator results, one bit per threshold
    // ==========================================================
    typedef struct packed {
        logic cell_above_overcharge_detect;    // Cell > overcharge detect
        logic cell_below_overcharge_release;   // Cell < overcharge release
        logic cell_below_overdischarge_detect; // Cell < overdischarge detect
        logic cell_above_overdischarge_release;// Cell > overdisch. release
        logic sense_below_charger_detect;      // Sense < charger detect
        logic sense_above_overcurrent;         // Sense > over-current
        logic sense_above_short_circuit;       // Sense > short circuit
        logic load_released;                   // Load impedance > 500k
    } cpf_cmp_s;

    // Gate and pin controls
    typedef struct packed {
        logic discharge_gate_out;  // Discharge FET on when high
        logic charge_gate_out;     // Charge FET on when high
        logic sense_pull_down;     // Sense pin pulled to ground
        logic sense_pull_up;       // Sense pin pulled to supply
        logic power_down;          // Power-down mode
    } cpf_ctl_s;

    localparam cpf_ctl_s CTL_RESET = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

endpackage

// ### rtl/cpf_protect.sv
// Overview of operation
// - Both FETs on in normal window
// - Long overcharge turns charge FET off
// - Long overdischarge: discharge off, pull-up, power-down
// - Leave power-down when sense drops below short
// - Charger detected: discharge on above overdischarge detect
// - Long reverse sense in normal: charge off
// - Sense above charger detect restores charge FET
// - Timed over-current or short-circuit detection
// - On fault: discharge off, pull-down on
// - Low cell during fault leads to power-down
// - Load released and sense low: back normal
// - Test pin shortens charge/discharge delays
//
// Top of the single-cell protection state machine.
// Assumes comparator results and the test pin come from outside the clock
// domain and are synchronised here before use.
`timescale 1ns/1ns

module cpf_protect (
    input  wire logic              sys_clk,            // 10 MHz clock
    input  wire logic              rst_n,              // Sync reset, low
    input  wire cpf_pkg::cpf_cmp_s cmp_in,             // Comparator results
    input  wire logic              delay_test_pin,     // Delay test strap
    output logic                   discharge_gate_out, // Discharge FET on
    output logic                   charge_gate_out,    // Charge FET on
    output logic                   sense_pull_down,    // Pull sense to gnd
    output logic                   sense_pull_up,      // Pull sense to vdd
    output logic                   power_down          // Power-down mode
);

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    cpf_pkg::cpf_cmp_s cmp_meta;   // First stage, read only by cmp
    cpf_pkg::cpf_cmp_s cmp;        // Second stage, safe to use
    logic              test_meta;  // First stage of test pin
    logic              test_sync;  // Second stage of test pin

    // Two flops on every pin before logic reads it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cmp_meta  <= '0;
            cmp       <= '0;
            test_meta <= 1'b0;
            test_sync <= 1'b0;
        end else begin
            cmp_meta  <= cmp_in;
            cmp       <= cmp_meta;
            test_meta <= delay_test_pin;
            test_sync <= test_meta;
        end
    end

    // ==========================================================
    // Delay limits
    // ==========================================================
    cpf_pkg::cpf_cnt_t lim_ovchg;  // Overcharge delay in cycles
    cpf_pkg::cpf_cnt_t lim_ovdis;  // Overdischarge delay in cycles

    assign lim_ovchg = test_sync
        ? cpf_pkg::cpf_cnt_t'(cpf_pkg::TEST_CYC)
        : cpf_pkg::cpf_cnt_t'(cpf_pkg::OVERCHARGE_CYC);
    assign lim_ovdis = test_sync
        ? cpf_pkg::cpf_cnt_t'(cpf_pkg::TEST_CYC)
        : cpf_pkg::cpf_cnt_t'(cpf_pkg::OVERDISCH_CYC);

    // ==========================================================
    // Full state
    // ==========================================================
    typedef struct packed {
        cpf_pkg::cpf_state_e state;  // Protection state
        cpf_pkg::cpf_ctl_s   ctl;    // Registered outputs
    } cpf_top_s;

    cpf_top_s st;       // Registered state
    cpf_top_s next_st;  // Next state

    // ==========================================================
    // Timer conditions
    // ==========================================================
    logic in_normal;  // Normal state
    logic in_fault;   // Over-current or short state
    logic c_ovchg;    // Overcharge condition
    logic c_abn;      // Abnormal charge current condition
    logic c_ovdis;    // Overdischarge condition
    logic c_ocur;     // Over-current condition
    logic c_short;    // Short-circuit condition
    logic e_ovchg;    // Expiry flags from the timers
    logic e_abn;
    logic e_ovdis;
    logic e_ocur;
    logic e_short;

    assign in_normal = (st.state == cpf_pkg::ST_NORMAL);
    assign in_fault  = (st.state == cpf_pkg::ST_OVCUR);

    assign c_ovchg = in_normal & cmp.cell_above_overcharge_detect;
    assign c_abn   = in_normal & ~cmp.cell_above_overcharge_detect
                   & cmp.sense_below_charger_detect;
    assign c_ovdis = (in_normal | in_fault)
                   & cmp.cell_below_overdischarge_detect;
    assign c_ocur  = in_normal & cmp.sense_above_overcurrent;
    assign c_short = in_normal & cmp.sense_above_short_circuit;

    cpf_delay_timer u_tmr_ovchg (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .cond    (c_ovchg),
        .limit   (lim_ovchg),
        .expired (e_ovchg)
    );

    cpf_delay_timer u_tmr_abn (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .cond    (c_abn),
        .limit   (lim_ovchg),
        .expired (e_abn)
    );

    cpf_delay_timer u_tmr_ovdis (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .cond    (c_ovdis),
        .limit   (lim_ovdis),
        .expired (e_ovdis)
    );

    cpf_delay_timer u_tmr_ocur (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .cond    (c_ocur),
        .limit   (cpf_pkg::cpf_cnt_t'(cpf_pkg::OVERCURRENT_CYC)),
        .expired (e_ocur)
    );

    cpf_delay_timer u_tmr_short (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .cond    (c_short),
        .limit   (cpf_pkg::cpf_cnt_t'(cpf_pkg::SHORT_CYC)),
        .expired (e_short)
    );

    // ==========================================================
    // Next-state logic
    // ==========================================================
    // Protection is ranked: overdischarge beats overload beats charge
    // faults, since a flat cell is the hazard that cannot wait.
    always_comb begin
        next_st = st;
        unique case (st.state)
            cpf_pkg::ST_NORMAL: begin
                if (e_ovdis) begin
                    next_st.state = cpf_pkg::ST_OVDIS;
                end else if (e_short || e_ocur) begin
                    next_st.state = cpf_pkg::ST_OVCUR;
                end else if (e_ovchg) begin
                    next_st.state = cpf_pkg::ST_OVCHG;
                end else if (e_abn) begin
                    next_st.state = cpf_pkg::ST_ABNCHG;
                end
            end
            cpf_pkg::ST_OVCHG: begin
                // Self discharge below release with sense in window,
                // or load pulls sense up while below detect
                if ((cmp.cell_below_overcharge_release
                     && !cmp.sense_below_charger_detect
                     && !cmp.sense_above_overcurrent)
                    || (cmp.sense_above_overcurrent
                        && !cmp.cell_above_overcharge_detect)) begin
                    next_st.state = cpf_pkg::ST_NORMAL;
                end
            end
            cpf_pkg::ST_ABNCHG: begin
                if (!cmp.sense_below_charger_detect) begin
                    next_st.state = cpf_pkg::ST_NORMAL;
                end
            end
            cpf_pkg::ST_OVDIS: begin
                if (cmp.sense_above_short_circuit) begin
                    next_st.state = cpf_pkg::ST_PWRDN;
                end
            end
            cpf_pkg::ST_PWRDN: begin
                if (!cmp.sense_above_short_circuit) begin
                    next_st.state = cpf_pkg::ST_WAKE;
                end
            end
            cpf_pkg::ST_WAKE: begin
                if (cmp.sense_below_charger_detect
                    && !cmp.cell_below_overdischarge_detect) begin
                    next_st.state = cpf_pkg::ST_NORMAL;
                end else if (!cmp.sense_below_charger_detect
                             && !cmp.sense_above_short_circuit
                             && cmp.cell_above_overdischarge_release) begin
                    next_st.state = cpf_pkg::ST_NORMAL;
                end else if (cmp.sense_above_short_circuit) begin
                    next_st.state = cpf_pkg::ST_PWRDN;
                end
            end
            cpf_pkg::ST_OVCUR: begin
                if (e_ovdis) begin
                    next_st.state = cpf_pkg::ST_PWRDN;
                end else if (cmp.load_released
                             && !cmp.sense_above_overcurrent
                             && !cmp.cell_below_overdischarge_detect) begin
                    next_st.state = cpf_pkg::ST_NORMAL;
                end
            end
            default: begin
                // Corrupt code: fall back to safe state
                next_st.state = cpf_pkg::ST_OVDIS;
            end
        endcase

        // Outputs follow the next state so they settle with it
        next_st.ctl = cpf_pkg::CTL_RESET;
        unique case (next_st.state)
            cpf_pkg::ST_NORMAL: begin
                next_st.ctl = cpf_pkg::CTL_RESET;
            end
            cpf_pkg::ST_OVCHG, cpf_pkg::ST_ABNCHG: begin
                next_st.ctl.charge_gate_out = 1'b0;
            end
            cpf_pkg::ST_OVDIS, cpf_pkg::ST_WAKE: begin
                next_st.ctl.discharge_gate_out = 1'b0;
                next_st.ctl.sense_pull_up      = 1'b1;
            end
            cpf_pkg::ST_PWRDN: begin
                next_st.ctl.discharge_gate_out = 1'b0;
                next_st.ctl.sense_pull_up      = 1'b1;
                next_st.ctl.power_down         = 1'b1;
            end
            cpf_pkg::ST_OVCUR: begin
                next_st.ctl.discharge_gate_out = 1'b0;
                next_st.ctl.sense_pull_down    = 1'b1;
            end
            default: begin
                next_st.ctl.discharge_gate_out = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st.state <= cpf_pkg::ST_NORMAL;
            st.ctl   <= cpf_pkg::CTL_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    assign discharge_gate_out = st.ctl.discharge_gate_out;
    assign charge_gate_out    = st.ctl.charge_gate_out;
    assign sense_pull_down    = st.ctl.sense_pull_down;
    assign sense_pull_up      = st.ctl.sense_pull_up;
    assign power_down         = st.ctl.power_down;

endmodule

// ### tb/cpf_cell_model.sv
// Model of cell, charger and load feeding the threshold comparators.
// Assumes voltages in millivolts; thresholds are plain defaults.
`timescale 1ns/1ns

module cpf_cell_model #(
    parameter int OCU_MV = 4300,   // Overcharge detect
    parameter int OCR_MV = 4100,   // Overcharge release
    parameter int ODL_MV = 2500,   // Overdischarge detect
    parameter int ODR_MV = 2900,   // Overdischarge release
    parameter int CHD_MV = -700,   // Charger detect
    parameter int OI1_MV = 150,    // Over-current
    parameter int OI2_MV = 1350    // Short circuit
) (
    input  wire logic        sense_pull_down,
    input  wire logic        sense_pull_up,
    input  var  int          cell_mv,
    input  var  int          load_mv,
    input  wire logic        load_open,
    output cpf_pkg::cpf_cmp_s cmp_in
);
    int sense_mv;  // Resolved sense pin level

    // With the load gone the internal pulls own the sense pin
    always_comb begin
        // Pull-down wins over pull-up; neither leaves the pin at ground
        sense_mv = load_open
            ? ((sense_pull_up && !sense_pull_down) ? cell_mv : 0)
            : load_mv;
        cmp_in.cell_above_overcharge_detect     = cell_mv > OCU_MV;
        cmp_in.cell_below_overcharge_release    = cell_mv < OCR_MV;
        cmp_in.cell_below_overdischarge_detect  = cell_mv < ODL_MV;
        cmp_in.cell_above_overdischarge_release = cell_mv > ODR_MV;
        cmp_in.sense_below_charger_detect       = sense_mv < CHD_MV;
        cmp_in.sense_above_overcurrent          = sense_mv > OI1_MV;
        cmp_in.sense_above_short_circuit        = sense_mv > OI2_MV;
        cmp_in.load_released                    = load_open;
    end
endmodule

// ### tb/cpf_protect_checker.sv
// Checker for the protection state machine, watching top-level ports only.
// Assumes one 10 MHz clock and a synchronous active-low reset.
`timescale 1ns/1ns

module cpf_protect_checker (
    input wire logic              sys_clk,
    input wire logic              rst_n,
    input wire cpf_pkg::cpf_cmp_s cmp_in,
    input wire logic              delay_test_pin,
    input wire logic              discharge_gate_out,
    input wire logic              charge_gate_out,
    input wire logic              sense_pull_down,
    input wire logic              sense_pull_up,
    input wire logic              power_down
);
    // ==========================================================
    // Helper logic
    // ==========================================================
    logic [19:0] hi_run;  // Unbroken cycles of high sense, saturating

    // Run length of high sense; restarts on any drop
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !(cmp_in.sense_above_short_circuit ||
                        cmp_in.sense_above_overcurrent)) begin
            hi_run <= 20'h0;
        end else if (hi_run != 20'hFFFFF) begin
            hi_run <= hi_run + 20'h1;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_reset_values: assert property ($rose(rst_n) |->
        discharge_gate_out && charge_gate_out && !sense_pull_down &&
        !sense_pull_up && !power_down) else $error("bad reset outputs");
    a_pd_pull_up: assert property (power_down |->
        sense_pull_up && !discharge_gate_out) else $error("bad power-down");
    a_pulls_apart: assert property (!(sense_pull_down && sense_pull_up))
        else $error("both pulls on");
    a_fault_dis_off: assert property (sense_pull_down |->
        !discharge_gate_out) else $error("discharge on in fault");
    a_short_delay: assert property ($rose(sense_pull_down) |->
        hi_run >= cpf_pkg::SHORT_CYC) else $error("fault entered early");
    a_fault_from_ok: assert property ($rose(sense_pull_down) |->
        $past(discharge_gate_out) && $past(charge_gate_out))
        else $error("fault not from normal");
    a_pd_entry_src: assert property ($rose(power_down) |->
        $past(sense_pull_up) || $past(sense_pull_down))
        else $error("power-down from wrong state");
    a_fault_release: assert property ((sense_pull_down &&
        cmp_in.load_released && !cmp_in.sense_above_overcurrent &&
        !cmp_in.sense_above_short_circuit &&
        !cmp_in.cell_below_overdischarge_detect) [*3] |->
        ##[1:3] (discharge_gate_out && !sense_pull_down))
        else $error("fault not released");

    c_reset: cover property ($rose(rst_n));
    c_fault: cover property ($rose(sense_pull_down));
    c_release: cover property ($fell(sense_pull_down));
    c_pwrdn: cover property ($rose(power_down));
endmodule

bind cpf_protect cpf_protect_checker u_cpf_protect_checker (
    .sys_clk(sys_clk), .rst_n(rst_n), .cmp_in(cmp_in),
    .delay_test_pin(delay_test_pin),
    .discharge_gate_out(discharge_gate_out),
    .charge_gate_out(charge_gate_out), .sense_pull_down(sense_pull_down),
    .sense_pull_up(sense_pull_up), .power_down(power_down));

// ### tb/tb.sv
// Self-checking bench for the protection state machine.
// Assumes the cell model drives the comparators; only test-pin delays and
// the short delay are run to expiry, the long ones would not fit the run.
`timescale 1ns/1ns

module tb;
    logic              sys_clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              delay_test_pin = 1'b0;
    int                cell_mv = 3700;
    int                load_mv = 0;
    logic              load_open = 1'b0;
    cpf_pkg::cpf_cmp_s cmp_in;
    logic              dis, chg, pdn, pup, pwr;
    int                bad_count = 0;
    int                checks_done = 0;
    int                n;
    logic [4:0]        outs;  // 4 dis, 3 chg, 2 pdn, 1 pup, 0 pwr
    localparam int     TLIM = int'(cpf_pkg::TEST_CYC) + 20;  // Test expiry

    assign outs = {dis, chg, pdn, pup, pwr};

    // ==========================================================
    // Clock, design and far side
    // ==========================================================
    always #50 sys_clk = ~sys_clk;

    cpf_protect u_cpf_protect (.sys_clk(sys_clk), .rst_n(rst_n),
        .cmp_in(cmp_in), .delay_test_pin(delay_test_pin),
        .discharge_gate_out(dis), .charge_gate_out(chg),
        .sense_pull_down(pdn), .sense_pull_up(pup), .power_down(pwr));
    cpf_cell_model u_cpf_cell_model (.sense_pull_down(pdn),
        .sense_pull_up(pup), .cell_mv(cell_mv), .load_mv(load_mv),
        .load_open(load_open), .cmp_in(cmp_in));

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic idle(input int k);
        repeat (k) @(negedge sys_clk);
    endtask

    // Bounded wait for the discharge gate to reach a level
    task automatic wait_dis(input logic lvl, input int lim);
        n = 0;
        while (dis !== lvl && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    // Bounded wait for one output bit to reach a level
    task automatic wait_out(input int idx, input logic lvl, input int lim);
        n = 0;
        while (outs[idx] !== lvl && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    task automatic end_of_test;
        if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    // Quiet cell and load: both gates on, pulls off
    task automatic t_normal;
        idle(50);
        check("outputs", {dis, chg, pdn, pup, pwr}, 5'h18);
    endtask

    // Over-current alone must not use the short timer
    task automatic t_overcurrent_only;
        load_mv = 500;
        idle(300);
        check("dis_oc", dis, 1'b1);
        load_mv = 0;
        idle(10);
    endtask

    // Broken shorts restart the timer; a long one trips it
    task automatic t_short;
        repeat (2) begin
            load_mv = 2000;
            idle(80);
            load_mv = 0;
            idle(3);
        end
        check("dis_glitch", dis, 1'b1);
        load_mv = 2000;
        wait_dis(1'b0, 300);
        check("short_delay", (n >= 100 && n <= 110), 1'b1);
        check("pull_down", pdn, 1'b1);
        check("chg_in_fault", chg, 1'b1);
    endtask

    // Release needs open load, low sense and a healthy cell
    task automatic t_release;
        load_mv = 100;
        idle(50);
        check("dis_load_on", dis, 1'b0);
        cell_mv = 2000;
        load_open = 1'b1;
        idle(100);
        check("dis_low_cell", {dis, pdn, pwr}, 3'h2);
        cell_mv = 3700;
        wait_dis(1'b1, 20);
        check("released", {dis, pdn, chg}, 3'h5);
        load_open = 1'b0;
        load_mv = 0;
        idle(10);
    endtask

    // Overcharge waits the long delay unless the test pin is high
    task automatic t_overcharge;
        check("test_ceiling", (cpf_pkg::TEST_CYC < cpf_pkg::OVERDISCH_CYC &&
              cpf_pkg::TEST_CYC <= cpf_pkg::TEST_MS * cpf_pkg::CLK_HZ / 1000),
              1'b1);
        cell_mv = 4400;
        idle(TLIM);
        check("chg_long_delay", chg, 1'b1);
        cell_mv = 3700;
        delay_test_pin = 1'b1;
        idle(5);
        cell_mv = 4400;
        wait_out(3, 1'b0, 2 * TLIM);
        check("ovchg_delay", (n >= TLIM - 20 && n <= TLIM), 1'b1);
        check("ovchg_outs", {dis, chg, pdn, pup, pwr}, 5'h10);
        cell_mv = 4000;
        wait_out(3, 1'b1, 20);
        check("ovchg_release", {dis, chg}, 2'h3);
    endtask

    // Charger pulling sense low in normal cuts the charge FET
    task automatic t_abnormal;
        load_mv = -1000;
        wait_out(3, 1'b0, 2 * TLIM);
        check("abn_delay", (n >= TLIM - 20 && n <= TLIM), 1'b1);
        check("abn_dis", dis, 1'b1);
        load_mv = 0;
        wait_out(3, 1'b1, 20);
        check("abn_release", chg, 1'b1);
    endtask

    // Flat cell, then load gone: pull-up lifts sense into power-down
    task automatic enter_pwrdn;
        cell_mv = 2000;
        wait_out(4, 1'b0, 2 * TLIM);
        check("ovdis_delay", (n >= TLIM - 20 && n <= TLIM), 1'b1);
        check("ovdis_outs", {dis, pup, pwr}, 3'h2);
        load_open = 1'b1;
        wait_out(0, 1'b1, 20);
        check("pwrdn_outs", {dis, pup, pwr}, 3'h3);
    endtask

    // Charger below detect: discharge back above overdischarge detect
    task automatic t_charger_detect;
        enter_pwrdn();
        load_open = 1'b0;
        load_mv = -1000;
        idle(20);
        check("wake_low_cell", {dis, pup, pwr}, 3'h2);
        cell_mv = 2600;
        wait_out(4, 1'b1, 20);
        check("chg_detect", {dis, chg, pup}, 3'h6);
        load_mv = 0;
        idle(10);
    endtask

    // Sense inside the window: discharge waits for overdischarge release
    task automatic t_release_threshold;
        enter_pwrdn();
        load_open = 1'b0;
        load_mv = 100;
        cell_mv = 2600;
        idle(20);
        check("wake_below_rel", {dis, pup, pwr}, 3'h2);
        cell_mv = 3000;
        wait_out(4, 1'b1, 20);
        check("rel_normal", {dis, chg, pup}, 3'h6);
        load_mv = 0;
    endtask

    // Flat cell during a short ends in power-down at overdischarge expiry
    task automatic t_fault_pwrdn;
        load_mv = 2000;
        wait_out(2, 1'b1, 300);
        cell_mv = 2000;
        idle(20);
        check("fault_low_cell", {dis, pdn, pwr}, 3'h2);
        wait_out(0, 1'b1, 2 * TLIM);
        check("fault_pwrdn", (n >= TLIM - 40 && n <= TLIM), 1'b1);
        load_mv = 0;
        cell_mv = 3700;
        wait_out(4, 1'b1, 20);
        check("pwrdn_exit", {dis, pdn, pwr}, 3'h4);
    endtask

    // ==========================================================
    // Main sequence and watchdog
    // ==========================================================
    initial begin
        // test pin starts at ground, normal delays until t_overcharge raises it
        delay_test_pin = 1'b0;
        idle(5);
        rst_n = 1'b1;
        t_normal();
        t_overcurrent_only();
        t_short();
        t_release();
        t_overcharge();
        t_abnormal();
        t_charger_detect();
        t_release_threshold();
        t_fault_pwrdn();
        end_of_test();
    end

    // Run needs about thirteen thousand cycles
    initial begin
        repeat (30000) @(posedge sys_clk);
        bad_count++;
        end_of_test();
    end
endmodule
